// File: hw/msc_regs.sv
// Interrupt and subsystem capability register bank with message write generator
// How it works
// RQ1: Capability control low byte always reads identifier 0x5.
// RQ2: Capability control next pointer byte reads zero: last in chain.
// RQ3: Enable bit, reset zero, gates interrupt message generation.
// RQ4: Message-capable field reads zero: one message requested.
// RQ5: Message-count enable field is writable, reset zero; behaviour stays single-message.
// RQ6: Wide address capable flag always reads one.
// RQ7: Lower address holds bits 31:2, reset zero; bits 1:0 read zero.
// RQ8: Non-zero upper address gives a 64-bit message write address.
// RQ9: Zero upper address gives a 32-bit write from the lower register.
// RQ10: Every message write is routed to the upstream port.
// RQ11: Software must program addresses that route upstream, else undefined.
// RQ12: Message data holds 16 writable bits, reset zero; upper half reserved.
// RQ13: Subsystem header low byte reads identifier 0xD; upper half reserved.
// RQ14: Subsystem next pointer is lockable writable, reset zero.
// RQ15: Subsystem low half is the lockable writable card maker code.
// RQ16: Subsystem high half is the lockable writable card model code.
// RQ17: Enabled internal event emits one write of payload to programmed address.
// RQ18: Reserved bits read zero and ignore writes.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "msc_defs.svh"

module msc_regs
  import msc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic MSI_EVENT,
  input wire logic MW_READY,
  output logic MW_VALID,
  output msc_mwr_type MW,
  output logic IRQ
);

  msc_state_type st_r;
  msc_state_type st_nxt;

  // Byte-lane merge of a write into an old register value
  function automatic logic [31:0] bmerge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Register offset match, byte address compared at full bus width
  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [7:0] off
  );
    return a == ADDR_W'(off);
  endfunction

  logic [31:0] cap_ctrl_word;
  logic [31:0] low_word;
  logic [31:0] data_word;
  logic [31:0] ss_hdr_word;
  logic [31:0] ss_id_word;
  logic [31:0] stat_word;
  logic [31:0] mask_word;
  logic [31:0] lock_word;

  always_comb begin
    cap_ctrl_word = {8'h00, `MSC_WIDE_CAPABLE, st_r.mce, `MSC_MSG_CAPABLE, st_r.en,
                     `MSC_MSI_NEXT_PTR, `MSC_MSI_CAP_ID}; // RQ1 RQ2 RQ4 RQ6 RQ18
    low_word = {st_r.low_addr, 2'b00}; // RQ7
    data_word = {16'h0000, st_r.payload}; // RQ12
    ss_hdr_word = {16'h0000, st_r.ss_next, `MSC_SS_CAP_ID}; // RQ13
    ss_id_word = {st_r.model, st_r.maker};
    stat_word = {30'h0000_0000, st_r.status};
    mask_word = {30'h0000_0000, st_r.mask};
    lock_word = {31'h0000_0000, st_r.lock};
  end

  logic req;
  logic wr_go;
  logic [31:0] rd_val;
  logic [31:0] wv;
  logic [1:0] ev;
  logic [1:0] w1c;
  logic msg_done;

  always_comb begin
    st_nxt = st_r;
    req = AVS_READ | AVS_WRITE;
    wr_go = AVS_WRITE & ~st_r.waitreq;
    ev = 2'b00;
    w1c = 2'b00;
    wv = 32'h0000_0000;
    msg_done = st_r.mw_valid & MW_READY;

    // Read mux; unmapped offsets read zero
    rd_val = 32'h0000_0000;
    if (hit(AVS_ADDRESS, `MSC_OFF_CAP_CTRL)) begin
      rd_val = cap_ctrl_word;
    end else if (hit(AVS_ADDRESS, `MSC_OFF_LOW_ADDR)) begin
      rd_val = low_word;
    end else if (hit(AVS_ADDRESS, `MSC_OFF_UP_ADDR)) begin
      rd_val = st_r.up_addr;
    end else if (hit(AVS_ADDRESS, `MSC_OFF_MSG_DATA)) begin
      rd_val = data_word;
    end else if (hit(AVS_ADDRESS, `MSC_OFF_IRQ_STATUS)) begin
      rd_val = stat_word;
    end else if (hit(AVS_ADDRESS, `MSC_OFF_IRQ_MASK)) begin
      rd_val = mask_word;
    end else if (hit(AVS_ADDRESS, `MSC_OFF_LOCK)) begin
      rd_val = lock_word;
    end else if (hit(AVS_ADDRESS, `MSC_OFF_SS_HEADER)) begin
      rd_val = ss_hdr_word;
    end else if (hit(AVS_ADDRESS, `MSC_OFF_SS_IDENT)) begin
      rd_val = ss_id_word;
    end

    // Two-phase answer: data and waitrequest low one cycle after the request is seen
    if (req && st_r.waitreq) begin
      st_nxt.waitreq = 1'b0;
      st_nxt.rdata = AVS_READ ? rd_val : 32'h0000_0000;
    end else begin
      st_nxt.waitreq = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
    end

    // Writes take effect at the edge where waitrequest is seen low
    if (wr_go) begin
      if (hit(AVS_ADDRESS, `MSC_OFF_CAP_CTRL)) begin
        wv = bmerge(cap_ctrl_word, AVS_WRITEDATA, AVS_BYTEENABLE);
        st_nxt.en = wv[`MSC_EN_BIT]; // RQ3
        st_nxt.mce = wv[`MSC_MCE_MSB:`MSC_MCE_LSB]; // RQ5
      end
      if (hit(AVS_ADDRESS, `MSC_OFF_LOW_ADDR)) begin
        wv = bmerge(low_word, AVS_WRITEDATA, AVS_BYTEENABLE);
        st_nxt.low_addr = wv[31:2]; // RQ7
      end
      if (hit(AVS_ADDRESS, `MSC_OFF_UP_ADDR)) begin
        st_nxt.up_addr = bmerge(st_r.up_addr, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
      if (hit(AVS_ADDRESS, `MSC_OFF_MSG_DATA)) begin
        wv = bmerge(data_word, AVS_WRITEDATA, AVS_BYTEENABLE);
        st_nxt.payload = wv[15:0]; // RQ12 RQ18
      end
      if (hit(AVS_ADDRESS, `MSC_OFF_IRQ_STATUS)) begin
        wv = bmerge(32'h0000_0000, AVS_WRITEDATA, AVS_BYTEENABLE);
        w1c = wv[1:0];
      end
      if (hit(AVS_ADDRESS, `MSC_OFF_IRQ_MASK)) begin
        wv = bmerge(mask_word, AVS_WRITEDATA, AVS_BYTEENABLE);
        st_nxt.mask = wv[1:0];
      end
      if (hit(AVS_ADDRESS, `MSC_OFF_LOCK)) begin
        wv = bmerge(lock_word, AVS_WRITEDATA, AVS_BYTEENABLE);
        st_nxt.lock = wv[0];
      end
      // Lock freezes the subsystem fields so firmware values survive host writes
      if (hit(AVS_ADDRESS, `MSC_OFF_SS_HEADER) && !st_r.lock) begin
        wv = bmerge(ss_hdr_word, AVS_WRITEDATA, AVS_BYTEENABLE);
        st_nxt.ss_next = wv[15:8]; // RQ14
      end
      if (hit(AVS_ADDRESS, `MSC_OFF_SS_IDENT) && !st_r.lock) begin
        wv = bmerge(ss_id_word, AVS_WRITEDATA, AVS_BYTEENABLE);
        st_nxt.maker = wv[15:0]; // RQ15
        st_nxt.model = wv[31:16]; // RQ16
      end
    end

    // Message generator: one outstanding write; events while one is owed merge
    if (msg_done) begin
      st_nxt.mw_valid = 1'b0;
      ev[`MSC_ST_SENT] = 1'b1;
    end
    if (MSI_EVENT) begin
      if (st_r.en) begin
        st_nxt.pend = 1'b1; // RQ3 RQ17
      end else begin
        ev[`MSC_ST_DROPPED] = 1'b1; // RQ3
      end
    end
    if (st_r.pend && st_r.en && (!st_r.mw_valid || msg_done)) begin
      st_nxt.pend = MSI_EVENT;
      st_nxt.mw_valid = 1'b1; // RQ17
      st_nxt.mw.wide = st_r.up_addr != 32'h0000_0000; // RQ8 RQ9
      if (st_r.up_addr != 32'h0000_0000) begin
        st_nxt.mw.addr = {st_r.up_addr, st_r.low_addr, 2'b00}; // RQ8
      end else begin
        st_nxt.mw.addr = {32'h0000_0000, st_r.low_addr, 2'b00}; // RQ9
      end
      // Only one message is ever allocated, so the count field never alters data
      st_nxt.mw.data = {16'h0000, st_r.payload}; // RQ5 RQ12
      st_nxt.mw.to_upstream = 1'b1; // RQ10 RQ11
    end
    if (!st_r.en) begin
      st_nxt.pend = 1'b0;
    end

    // Sticky status: a new event wins over a clear in the same cycle
    st_nxt.status = (st_r.status & ~w1c) | ev;
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_r <= '0;
      st_r.waitreq <= 1'b1;
      st_r.ss_next <= `MSC_SS_NEXT_PTR_RST; // RQ14
    end else begin
      st_r <= st_nxt;
    end
  end

  assign AVS_READDATA = st_r.rdata;
  assign AVS_WAITREQUEST = st_r.waitreq;
  assign MW_VALID = st_r.mw_valid;
  assign MW = st_r.mw;
  assign IRQ = st_r.irq;

endmodule

`default_nettype wire

// File: inc/msc_defs.svh
// Offsets, field positions, reset values and constants of the interrupt capability bank
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH

`define MSC_OFF_CAP_CTRL 8'h0d0
`define MSC_OFF_LOW_ADDR 8'h0d4
`define MSC_OFF_UP_ADDR 8'h0d8
`define MSC_OFF_MSG_DATA 8'h0dc
`define MSC_OFF_IRQ_STATUS 8'h0e0
`define MSC_OFF_IRQ_MASK 8'h0e4
`define MSC_OFF_LOCK 8'h0e8
`define MSC_OFF_SS_HEADER 8'h0f0
`define MSC_OFF_SS_IDENT 8'h0f4

`define MSC_MSI_CAP_ID 8'h05
`define MSC_SS_CAP_ID 8'h0d
`define MSC_MSI_NEXT_PTR 8'h00
`define MSC_SS_NEXT_PTR_RST 8'h00
`define MSC_MSG_CAPABLE 3'h0
`define MSC_WIDE_CAPABLE 1'b1

`define MSC_EN_BIT 16
`define MSC_MCE_LSB 20
`define MSC_MCE_MSB 22

`define MSC_ST_SENT 0
`define MSC_ST_DROPPED 1
`define MSC_NUM_EVENTS 2

`endif

// File: inc/msc_pkg.sv
// Types shared by the interrupt capability bank and its bench
package msc_pkg;

  typedef struct packed {
    logic [63:0] addr;
    logic wide;
    logic [31:0] data;
    logic to_upstream;
  } msc_mwr_type;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic en;
    logic [2:0] mce;
    logic [29:0] low_addr;
    logic [31:0] up_addr;
    logic [15:0] payload;
    logic [7:0] ss_next;
    logic [15:0] maker;
    logic [15:0] model;
    logic lock;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic pend;
    logic mw_valid;
    msc_mwr_type mw;
  } msc_state_type;

endpackage

// File: bench/msc_regs_chk.sv
// Port assertions for the capability bank
`timescale 1ns/1ps
`default_nettype none
module msc_regs_chk
  import msc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic MW_READY,
  input wire logic MW_VALID,
  input wire msc_mwr_type MW
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire logic req = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  wire logic rd = AVS_READ && AVS_WAITREQUEST;
  wire logic [31:0] q = AVS_READDATA;
  a_answer_next: assert property (req |=> !AVS_WAITREQUEST)
    else $error("no answer");
  a_answer_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("long answer");
  a_cap_fields: assert property (rd && AVS_ADDRESS == 8'hd0 |=> q[7:0] == 8'h05
    && q[15:8] == 8'h0 && q[19:17] == 3'h0 && q[31:23] == 9'h001) else $error("bad control");
  a_ss_header: assert property (rd && AVS_ADDRESS == 8'hf0 |=> q == {16'h0, q[15:8], 8'h0d})
    else $error("bad header");
  a_data_rsvd: assert property (rd && AVS_ADDRESS == 8'hdc |=> q[31:16] == 16'h0)
    else $error("bad data");
  a_mw_hold: assert property (MW_VALID && !MW_READY |=> MW_VALID && $stable(MW))
    else $error("write dropped");
  a_mw_route: assert property (MW_VALID |-> MW.to_upstream && MW.addr[1:0] == 2'h0
    && MW.data[31:16] == 16'h0) else $error("bad write");
  a_mw_width: assert property (MW_VALID |-> MW.wide == (MW.addr[63:32] != 32'h0))
    else $error("bad width");
  c_wide: cover property (MW_VALID && MW_READY && MW.wide);
  c_narrow: cover property (MW_VALID && MW_READY && !MW.wide);
  c_read: cover property (rd);
endmodule
bind msc_regs msc_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.CLK(CLK), .RSTN(RSTN),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .MW_READY(MW_READY), .MW_VALID(MW_VALID), .MW(MW));
`default_nettype wire

// File: bench/msc_upstream.sv
// Upstream receiver of message writes
`timescale 1ns/1ps
`default_nettype none
module msc_upstream
  import msc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mw_valid,
  input wire msc_mwr_type mw,
  input wire logic [3:0] delay,
  output logic mw_ready,
  output int got,
  output msc_mwr_type last
);
  logic [3:0] wait_r;
  // Ready only after the offer is seen, so a slow host really stalls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mw_ready <= 1'b0;
      wait_r <= 4'h0;
      got <= 0;
      last <= '0;
    end else if (mw_valid && mw_ready) begin
      mw_ready <= 1'b0;
      wait_r <= 4'h0;
      got <= got + 1;
      last <= mw;
    end else if (mw_valid && wait_r == delay) begin
      mw_ready <= 1'b1;
    end else if (mw_valid) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: bench/msc_regs_tb.sv
// Bench for the capability bank
`timescale 1ns/1ps
`default_nettype none
module msc_regs_tb
  import msc_pkg::*;
;
  logic CLK = 0, RSTN = 0, rd = 0, wr = 0, ev = 0, wt, mv, mr, irq;
  logic [7:0] a = 8'h0;
  logic [31:0] wd = 32'h0, q, r;
  logic [3:0] dl = 4'h0;
  logic [3:0] be = 4'hf;
  msc_mwr_type mw, last;
  int got, compares, fail_count, cyc, n;
  logic [7:0] ta[7] = '{8'hd0, 8'hd4, 8'hd8, 8'hdc, 8'hf0, 8'hf4, 8'h10};
  logic [31:0] tr[7] = '{32'h0080_0005, 32'h0, 32'h0, 32'h0, 32'hd, 32'h0, 32'h0};
  logic [31:0] tw[7] = '{32'hff71_0005, '1, 32'h8000_0001, '1, 32'hffff_ff00, 32'h1234_5678, '1};
  logic [31:0] te[7] = '{32'h00f1_0005, 32'hffff_fffc, 32'h8000_0001, 32'hffff, 32'hff0d,
    32'h1234_5678, 32'h0};
  msc_regs DUT (.CLK(CLK), .RSTN(RSTN), .AVS_ADDRESS(a), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(q), .AVS_WAITREQUEST(wt),
    .MSI_EVENT(ev), .MW_READY(mr), .MW_VALID(mv), .MW(mw), .IRQ(irq));
  msc_upstream u_up (.clk(CLK), .rst_n(RSTN), .mw_valid(mv), .mw(mw), .delay(dl),
    .mw_ready(mr), .got(got), .last(last));
  initial forever #25 CLK = ~CLK;
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    a <= ad;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge CLK); while (wt !== 1'b0);
    r = q;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic chk(input string s, input logic [63:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic pulse;
    n = got;
    ev <= 1'b1;
    @(posedge CLK);
    ev <= 1'b0;
  endtask
  task automatic t_regs;
    for (int i = 0; i < 7; i++) begin
      bus(0, ta[i], 32'h0);
      chk("reset", r, tr[i]);
      bus(1, ta[i], tw[i]);
      bus(0, ta[i], 32'h0);
      chk("readback", r, te[i]);
    end
    bus(1, 8'he8, 32'h1);
    bus(1, 8'hf4, 32'h0);
    bus(0, 8'hf4, 32'h0);
    chk("locked", r, 32'h1234_5678);
    bus(1, 8'he8, 32'h0);
    // Only the lowest lane is written, the other three bytes must survive
    be <= 4'h1;
    bus(1, 8'hd8, 32'h0000_0000);
    be <= 4'hf;
    bus(0, 8'hd8, 32'h0);
    chk("lanes", r, 32'h8000_0000);
    $display("registers done");
  endtask
  task automatic t_msg(input logic [31:0] up, input logic [3:0] d);
    dl <= d;
    bus(1, 8'hd0, 32'h0071_0000);
    bus(1, 8'hd8, up);
    bus(1, 8'hd4, 32'h8765_4323);
    bus(1, 8'hdc, 32'hffff_a5a5);
    bus(1, 8'he4, 32'h3);
    pulse();
    repeat (20) if (got == n) @(posedge CLK);
    chk("count", got - n, 1);
    chk("addr", last.addr, {up, 32'h8765_4320});
    chk("wide", last.wide, up != 0);
    chk("data", last.data, 32'ha5a5);
    chk("route", last.to_upstream, 1);
    chk("irq", irq, 1);
    bus(1, 8'he0, 32'h1);
    chk("irq off", irq, 0);
    $display("message done");
  endtask
  task automatic t_drop;
    bus(1, 8'hd0, 32'h0);
    pulse();
    // Six cycles, short of the 8 a write that must not appear would take with dl still at 5
    repeat (6) @(posedge CLK);
    chk("count", got - n, 0);
    bus(0, 8'he0, 32'h0);
    chk("status", r, 32'h2);
    chk("irq", irq, 1);
    bus(1, 8'he0, 32'h2);
    chk("irq off", irq, 0);
    $display("drop done");
  endtask
  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    t_regs();
    t_msg(32'h0, 4'h0);
    t_msg(32'ha1, 4'h5);
    t_drop();
    test_done();
  end
endmodule
`default_nettype wire
